/* slcal_pkg.sv */
// Shared constants, types and decode functions of the link block
package slcal_pkg;

    localparam int SYM_W  = 14;
    localparam int PAY_W  = 12;
    localparam int HALF_W = 7;
    localparam logic [1:0]       HDR_DATA  = 2'h0;
    localparam logic [1:0]       HDR_CMD   = 2'h2;
    localparam logic [SYM_W-1:0] SYNC_SYM  = 14'h3fff;
    localparam logic [6:0]       SYNC_HALF = 7'h7f;

    localparam int CLK_NS         = 5;
    localparam int LINK_BIT_NS    = 64;
    // Guard covers the crossing jitter of the boundary events
    localparam int BYTE_GUARD_CYC = 2;
    localparam int BYTE_MIN_CYC   = (SYM_W * LINK_BIT_NS) / CLK_NS
                                    - BYTE_GUARD_CYC;
    localparam int CNT_W          = 8;
    localparam int TB_WIN_DEF     = 2;
    localparam int RX_TEST_BITS   = 32;

    typedef enum logic [1:0] {
        SLCAL_W8  = 2'h0,
        SLCAL_W9  = 2'h1,
        SLCAL_W10 = 2'h2
    } slcal_wmode_t;

    typedef enum logic [1:0] {
        SLCAL_TX_NORM = 2'h0,
        SLCAL_TX_NRZ  = 2'h1,
        SLCAL_TX_BYP  = 2'h2
    } slcal_txtest_t;

    typedef enum logic [2:0] {
        SLCAL_CAS_IDLE = 3'h1,
        SLCAL_CAS_HOLD = 3'h2,
        SLCAL_CAS_XFER = 3'h4
    } slcal_cas_t;

    typedef enum logic [1:0] {
        SLCAL_RX_HUNT = 2'h1,
        SLCAL_RX_LOCK = 2'h2
    } slcal_rx_t;

    function automatic logic [3:0] slcal_dwidth(input logic [1:0] mode);
        case (mode)
            SLCAL_W9:  return 4'h9;
            SLCAL_W10: return 4'ha;
            default:   return 4'h8;
        endcase
    endfunction : slcal_dwidth

    function automatic logic [PAY_W-1:0] slcal_dmask(input logic [1:0] mode);
        return 12'hfff >> (4'hc - slcal_dwidth(mode));
    endfunction : slcal_dmask
endpackage : slcal_pkg

/* slcal_sync2.sv */
// Two-stage synchroniser for levels and toggles
`timescale 1ns/1ps
module slcal_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : slcal_sync2

/* slcal_deframe.sv */
// Receive symbol framer on the link clock
`timescale 1ns/1ps
module slcal_deframe
    import slcal_pkg::*;
(
    input  wire logic             link_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             bit_en_i,
    input  wire logic             bit_i,
    output logic      [SYM_W-1:0] sym_o,
    output logic                  sym_tgl_o,
    output logic                  sync_tgl_o,
    output logic                  half_tgl_o,
    output logic                  locked_o
);
    slcal_rx_t        state_q;
    logic [SYM_W-1:0] shift_q;
    logic [SYM_W-1:0] next_w;
    logic [3:0]       cnt_q;

    assign next_w = {shift_q[SYM_W-2:0], bit_i};

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift_q <= '0;
        end else if (bit_en_i) begin
            shift_q <= next_w;
        end
    end

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q    <= SLCAL_RX_HUNT;
            cnt_q      <= 4'h0;
            sym_o      <= '0;
            sym_tgl_o  <= 1'b0;
            sync_tgl_o <= 1'b0;
            half_tgl_o <= 1'b0;
            locked_o   <= 1'b0;
        end else if (bit_en_i) begin
            case (state_q)
                SLCAL_RX_HUNT: begin
                    // Partial byte before relock is simply never framed
                    if (next_w == SYNC_SYM) begin
                        state_q    <= SLCAL_RX_LOCK;
                        cnt_q      <= 4'h0;
                        sync_tgl_o <= ~sync_tgl_o;
                        locked_o   <= 1'b1;
                    end
                end
                SLCAL_RX_LOCK: begin
                    if (cnt_q == 4'(SYM_W - 1)) begin
                        cnt_q <= 4'h0;
                        if (next_w == SYNC_SYM) begin
                            sync_tgl_o <= ~sync_tgl_o;
                        end else if (!next_w[SYM_W-2]) begin
                            sym_o     <= next_w;
                            sym_tgl_o <= ~sym_tgl_o;
                        end else begin
                            state_q  <= SLCAL_RX_HUNT;
                            locked_o <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'(HALF_W - 1)
                                && next_w[HALF_W-1:0] == SYNC_HALF) begin
                            half_tgl_o <= ~half_tgl_o;
                        end
                    end
                end
                default: begin
                    state_q <= SLCAL_RX_HUNT;
                end
            endcase
        end
    end
endmodule : slcal_deframe

/* slcal_top.sv */
// Link transmitter alignment and cascaded receiver capture
`timescale 1ns/1ps
module slcal_top
    import slcal_pkg::*;
#(
    parameter int TB_WIN = TB_WIN_DEF
) (
    input  wire logic        mclk_i,
    input  wire logic        link_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [1:0]  width_mode_select_i,
    input  wire logic [1:0]  tx_test_select_i,
    input  wire logic        input_strobe_i,
    input  wire logic [11:0] tx_word_i,
    output logic             tx_ack_o,
    output logic             tx_serial_o,
    output logic             tx_byte_clk_o,
    input  wire logic        serial_in_pos_i,
    input  wire logic        serial_in_neg_i,
    input  wire logic        crystal_in_i,
    input  wire logic        cascade_en_i,
    input  wire logic        catch_next_in_i,
    output logic             got_mine_out_o,
    output logic [9:0]       rx_data_o,
    output logic [3:0]       rx_cmd_o,
    output logic             data_strobe_o,
    output logic             command_strobe_o,
    output logic             rx_byte_clk_o,
    output logic             rx_locked_o
);
    if (TB_WIN < 1 || TB_WIN > SYM_W - 2) begin : g_bad_win
        $error("TB_WIN out of range");
    end
    if (BYTE_MIN_CYC >= (1 << CNT_W)) begin : g_bad_cnt
        $error("Byte time does not fit the pulse counter");
    end

    localparam logic [CNT_W-1:0] PER_MIN = CNT_W'(BYTE_MIN_CYC);
    localparam logic [CNT_W-1:0] PER_HI  = CNT_W'(BYTE_MIN_CYC / 2);

    // Host write side, main clock
    logic [PAY_W-1:0] word_s;
    logic             stb_s;
    logic             stb_d_q;
    logic             ack_tgl_s;
    logic             take_pend_q;
    logic             in_full_q;
    logic [PAY_W-1:0] in_q;
    logic [PAY_W-1:0] xf_q;
    logic             req_tgl_q;
    logic             stb_rise;
    logic             xf_busy;
    logic             take;
    logic             move;
    // Serial send side, link clock
    logic [4:0]       tx_lk_s;
    logic             req_s;
    logic [1:0]       tx_mode_s;
    logic [1:0]       tx_test_s;
    logic [3:0]       div_q;
    logic [3:0]       bit_cnt_q;
    logic [SYM_W-1:0] tx_shift_q;
    logic [SYM_W-1:0] tx_sym;
    logic [PAY_W-1:0] tx_cmd_bits;
    logic             ack_tgl_q;
    logic             seen_q;
    logic             late_q;
    logic             tick;
    logic             boundary;
    logic             req_new;
    logic             load;
    // Serial receive side, link clock
    logic [2:0]       rx_pin_s;
    logic             xtal_d_q;
    logic [5:0]       neg_lo_q;
    logic             rx_test_q;
    logic             prev_q;
    logic             bit_en;
    logic [SYM_W-1:0] rx_sym;
    logic             sym_tgl;
    logic             sync_tgl;
    logic             half_tgl;
    logic             locked;
    // Receive host side, main clock
    logic [7:0]       rx_cr_s;
    logic [2:0]       tgl_d_q;
    logic             ev_sym;
    logic             ev_sync;
    logic             ev_half;
    logic             catch_s;
    logic             casc_s;
    logic [1:0]       rx_mode_s;
    slcal_cas_t       cas_q;
    logic [SYM_W-1:0] hold_q;
    logic             deliver;
    logic [SYM_W-1:0] dlv_w;
    logic [CNT_W-1:0] per_q;
    logic             rclk_pend_q;
    logic             rclk_want;

    slcal_sync2 #(.W(PAY_W + 2)) u_tx_host_sync (
        .clk_i (mclk_i),
        .rst_i (sys_rst_i),
        .d_i   ({input_strobe_i, ack_tgl_q, tx_word_i}),
        .q_o   ({stb_s, ack_tgl_s, word_s})
    );

    assign stb_rise = stb_s & ~stb_d_q;
    assign xf_busy  = req_tgl_q ^ ack_tgl_s;
    assign take     = (stb_rise | take_pend_q) & ~in_full_q;
    assign move     = in_full_q & ~xf_busy;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stb_d_q     <= 1'b0;
            take_pend_q <= 1'b0;
            tx_ack_o    <= 1'b0;
        end else begin
            stb_d_q <= stb_s;
            // A second early strobe waits here; a third is lost
            take_pend_q <= (take_pend_q | stb_rise) & ~take;
            if (take) begin
                tx_ack_o <= 1'b1;
            end else if (!stb_s) begin
                tx_ack_o <= 1'b0;
            end
        end
    end

    // Input latch plus hand-over word form the two-word buffer
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            in_full_q <= 1'b0;
            in_q      <= '0;
            xf_q      <= '0;
            req_tgl_q <= 1'b0;
        end else begin
            in_full_q <= (in_full_q & ~move) | take;
            if (take) begin
                in_q <= word_s;
            end
            if (move) begin
                xf_q      <= in_q;
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    slcal_sync2 #(.W(5)) u_tx_link_sync (
        .clk_i (link_clk_i),
        .rst_i (sys_rst_i),
        .d_i   ({req_tgl_q, width_mode_select_i, tx_test_select_i}),
        .q_o   (tx_lk_s)
    );

    assign req_s     = tx_lk_s[4];
    assign tx_mode_s = tx_lk_s[3:2];
    assign tx_test_s = tx_lk_s[1:0];

    // Bypass runs one bit per symbol time of the link clock
    assign tick     = (tx_test_s != SLCAL_TX_BYP) || (div_q == 4'h0);
    assign boundary = tick && (bit_cnt_q == 4'(SYM_W - 1));
    assign req_new  = req_s ^ ack_tgl_q;
    assign load     = boundary && req_new && seen_q && !late_q;
    assign tx_cmd_bits = xf_q & ~slcal_dmask(tx_mode_s);
    assign tx_sym = (tx_cmd_bits != '0) ? {HDR_CMD, tx_cmd_bits}
                  : {HDR_DATA, xf_q & slcal_dmask(tx_mode_s)};

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= 4'h0;
        end else if (div_q == 4'(SYM_W - 1)) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // A word seen inside the window waits one more slot
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_q <= 1'b0;
            late_q <= 1'b0;
        end else if (load) begin
            seen_q <= 1'b0;
            late_q <= 1'b0;
        end else if (boundary) begin
            late_q <= 1'b0;
        end else if (tick && req_new && !seen_q) begin
            seen_q <= 1'b1;
            late_q <= bit_cnt_q >= 4'(SYM_W - TB_WIN);
        end
    end

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt_q     <= 4'h0;
            tx_shift_q    <= SYNC_SYM;
            ack_tgl_q     <= 1'b0;
            tx_serial_o   <= 1'b0;
            tx_byte_clk_o <= 1'b0;
        end else if (tick) begin
            if (boundary) begin
                bit_cnt_q <= 4'h0;
                // Idle slots carry sync so the far end keeps alignment
                tx_shift_q <= load ? tx_sym : SYNC_SYM;
            end else begin
                bit_cnt_q  <= bit_cnt_q + 4'h1;
                tx_shift_q <= {tx_shift_q[SYM_W-2:0], 1'b0};
            end
            if (load) begin
                ack_tgl_q <= ~ack_tgl_q;
            end
            if (tx_test_s == SLCAL_TX_NRZ) begin
                tx_serial_o <= tx_shift_q[SYM_W-1];
            end else begin
                tx_serial_o <= tx_serial_o ^ tx_shift_q[SYM_W-1];
            end
            tx_byte_clk_o <= (bit_cnt_q >= 4'(HALF_W - 1)) && !boundary;
        end
    end

    slcal_sync2 #(.W(3)) u_rx_pin_sync (
        .clk_i (link_clk_i),
        .rst_i (sys_rst_i),
        .d_i   ({serial_in_pos_i, serial_in_neg_i, crystal_in_i}),
        .q_o   (rx_pin_s)
    );

    // Differential traffic never holds the low side this long
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xtal_d_q  <= 1'b0;
            neg_lo_q  <= 6'h00;
            rx_test_q <= 1'b0;
        end else begin
            xtal_d_q <= rx_pin_s[0];
            if (rx_pin_s[1]) begin
                neg_lo_q  <= 6'h00;
                rx_test_q <= 1'b0;
            end else if (neg_lo_q != 6'(RX_TEST_BITS)) begin
                neg_lo_q <= neg_lo_q + 6'h01;
            end else begin
                rx_test_q <= 1'b1;
            end
        end
    end

    assign bit_en = rx_test_q ? (rx_pin_s[0] & ~xtal_d_q) : 1'b1;

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_q <= 1'b0;
        end else if (bit_en) begin
            prev_q <= rx_pin_s[2];
        end
    end

    slcal_deframe u_deframe (
        .link_clk_i (link_clk_i),
        .sys_rst_i  (sys_rst_i),
        .bit_en_i   (bit_en),
        .bit_i      (rx_pin_s[2] ^ prev_q),
        .sym_o      (rx_sym),
        .sym_tgl_o  (sym_tgl),
        .sync_tgl_o (sync_tgl),
        .half_tgl_o (half_tgl),
        .locked_o   (locked)
    );

    slcal_sync2 #(.W(8)) u_rx_host_sync (
        .clk_i (mclk_i),
        .rst_i (sys_rst_i),
        .d_i   ({sym_tgl, sync_tgl, half_tgl, locked, catch_next_in_i,
                 cascade_en_i, width_mode_select_i}),
        .q_o   (rx_cr_s)
    );

    assign ev_sym    = rx_cr_s[7] ^ tgl_d_q[2];
    assign ev_sync   = rx_cr_s[6] ^ tgl_d_q[1];
    assign ev_half   = rx_cr_s[5] ^ tgl_d_q[0];
    assign catch_s   = rx_cr_s[3];
    assign casc_s    = rx_cr_s[2];
    assign rx_mode_s = rx_cr_s[1:0];
    assign deliver   = (cas_q == SLCAL_CAS_XFER) || (ev_sym && !casc_s);
    assign dlv_w     = (cas_q == SLCAL_CAS_XFER) ? hold_q : rx_sym;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgl_d_q     <= 3'h0;
            rx_locked_o <= 1'b0;
        end else begin
            tgl_d_q     <= rx_cr_s[7:5];
            rx_locked_o <= rx_cr_s[4];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cas_q  <= SLCAL_CAS_IDLE;
            hold_q <= '0;
        end else begin
            case (cas_q)
                SLCAL_CAS_IDLE: begin
                    if (ev_sym && casc_s && catch_s) begin
                        hold_q <= rx_sym;
                        cas_q  <= SLCAL_CAS_HOLD;
                    end
                end
                SLCAL_CAS_HOLD: begin
                    if (ev_sync || !catch_s) begin
                        cas_q <= SLCAL_CAS_XFER;
                    end
                end
                SLCAL_CAS_XFER: begin
                    cas_q <= SLCAL_CAS_IDLE;
                end
                default: begin
                    cas_q <= SLCAL_CAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            got_mine_out_o <= 1'b0;
        end else if (ev_half || ev_sync || !catch_s) begin
            got_mine_out_o <= 1'b0;
        end else if (cas_q == SLCAL_CAS_IDLE && ev_sym && casc_s) begin
            got_mine_out_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_data_o        <= '0;
            rx_cmd_o         <= '0;
            data_strobe_o    <= 1'b0;
            command_strobe_o <= 1'b0;
        end else begin
            data_strobe_o    <= 1'b0;
            command_strobe_o <= 1'b0;
            if (deliver) begin
                if (dlv_w[SYM_W-1]) begin
                    rx_cmd_o <= 4'(dlv_w[PAY_W-1:0]
                                   >> slcal_dwidth(rx_mode_s));
                    command_strobe_o <= 1'b1;
                end else begin
                    rx_data_o <= 10'(dlv_w[PAY_W-1:0]
                                     & slcal_dmask(rx_mode_s));
                    data_strobe_o <= 1'b1;
                end
            end else if (ev_sync && cas_q != SLCAL_CAS_HOLD) begin
                rx_cmd_o         <= '0;
                command_strobe_o <= 1'b1;
            end
        end
    end

    // Boundaries jump on relock; the clock never runs faster
    assign rclk_want = ev_sym | ev_sync | rclk_pend_q;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            per_q         <= PER_MIN;
            rclk_pend_q   <= 1'b0;
            rx_byte_clk_o <= 1'b0;
        end else if (rclk_want && per_q >= PER_MIN) begin
            per_q         <= '0;
            rclk_pend_q   <= 1'b0;
            rx_byte_clk_o <= 1'b1;
        end else begin
            rclk_pend_q <= rclk_want;
            if (per_q != PER_MIN) begin
                per_q <= per_q + CNT_W'(1);
            end
            if (per_q == PER_HI) begin
                rx_byte_clk_o <= 1'b0;
            end
        end
    end

    // Checking helpers
    logic             rclk_d_q;
    logic [CNT_W-1:0] gap_q;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rclk_d_q <= 1'b0;
            gap_q    <= '1;
        end else begin
            rclk_d_q <= rx_byte_clk_o;
            if (rx_byte_clk_o && !rclk_d_q) begin
                gap_q <= CNT_W'(1);
            end else if (gap_q != '1) begin
                gap_q <= gap_q + CNT_W'(1);
            end
        end
    end

    gm_set_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cas_q == SLCAL_CAS_IDLE && ev_sym && casc_s && catch_s
        |=> got_mine_out_o && cas_q == SLCAL_CAS_HOLD)
        else $error("got-mine not raised after capture");
    gm_half_drop_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ev_half || !catch_s |=> !got_mine_out_o)
        else $error("got-mine stayed high");
    catch_gate_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cas_q == SLCAL_CAS_IDLE && ev_sym && casc_s && !catch_s
        |=> cas_q == SLCAL_CAS_IDLE && !got_mine_out_o)
        else $error("symbol taken without catch");
    hold_xfer_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cas_q == SLCAL_CAS_HOLD && ev_sync
        |=> ##1 (data_strobe_o || command_strobe_o))
        else $error("held symbol not moved after sync");
    sync_clear_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ev_sync && cas_q == SLCAL_CAS_IDLE && !(ev_sym && !casc_s)
        |=> command_strobe_o && rx_cmd_o == '0 && $stable(rx_data_o))
        else $error("sync did not clear commands");
    rclk_stretch_a:
    assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(rx_byte_clk_o) |-> gap_q > PER_MIN)
        else $error("receive clock pulse too short");
    idle_sync_a:
    assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        boundary && !load |=> tx_shift_q == SYNC_SYM)
        else $error("idle slot without sync");
    win_defer_a:
    assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        boundary && req_new && late_q
        |=> tx_shift_q == SYNC_SYM && !late_q && req_new)
        else $error("late word not deferred one slot");
    nrz_out_a:
    assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
        tick && tx_test_s == SLCAL_TX_NRZ
        |=> tx_serial_o == $past(tx_shift_q[SYM_W-1]))
        else $error("NRZ test output wrong");
endmodule : slcal_top

/* slcal_host.sv */
// Sending host model with strobe and acknowledge handshake
`timescale 1ns/1ps
module slcal_host (
    input  wire logic        mclk_i,
    input  wire logic        tx_ack_i,
    input  wire logic        byte_clk_i,
    output logic             strobe_o,
    output logic [11:0]      word_o
);
    initial begin
        strobe_o = 1'b0;
        word_o   = 12'h0000;
    end
    // Waits out each acknowledge so the two-word buffer never overfills
    task automatic send(input logic [11:0] w);
        @(negedge mclk_i);
        word_o   = w;
        strobe_o = 1'b1;
        do @(posedge mclk_i); while (tx_ack_i !== 1'b1);
        @(negedge mclk_i);
        strobe_o = 1'b0;
        word_o   = ~w;
        do @(posedge mclk_i); while (tx_ack_i !== 1'b0);
    endtask : send

    // Paced by the byte clock where the handshake is too slow
    task automatic sync_send(input logic [11:0] w);
        @(negedge byte_clk_i);
        @(negedge mclk_i);
        word_o   = w;
        strobe_o = 1'b1;
        repeat (8) @(negedge mclk_i);
        strobe_o = 1'b0;
        do @(posedge mclk_i); while (tx_ack_i !== 1'b0);
    endtask : sync_send
endmodule : slcal_host

/* slcal_top_tb.sv */
// Loopback bench: host words through transmitter back to receiver
`timescale 1ns/1ps
module slcal_top_tb;
    import slcal_pkg::*;
    logic        mclk_i;
    logic        link_clk_i;
    logic        sys_rst_i;
    logic [1:0]  wmode;
    logic        stb;
    logic [11:0] word;
    logic        ack;
    logic        ser;
    logic [9:0]  rx_data;
    logic [3:0]  rx_cmd;
    logic        dstb;
    logic        cstb;
    logic        locked;
    logic        bclk;
    logic        rbclk;
    logic        rbclk_d;
    logic        casc;
    logic        catch_in;
    logic        gm;
    int          gap;
    logic [9:0]  exp_q[$];
    int          err_count;
    int          n_compared;
    int          cyc;

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #7;
        forever #32 link_clk_i = ~link_clk_i;
    end

    slcal_host host_u (.mclk_i(mclk_i), .tx_ack_i(ack), .byte_clk_i(bclk),
                       .strobe_o(stb), .word_o(word));

    slcal_top dut_u (
        .mclk_i(mclk_i), .link_clk_i(link_clk_i), .sys_rst_i(sys_rst_i),
        .width_mode_select_i(wmode), .tx_test_select_i(2'h0),
        .input_strobe_i(stb), .tx_word_i(word), .tx_ack_o(ack),
        .tx_serial_o(ser), .tx_byte_clk_o(bclk), .serial_in_pos_i(ser),
        .serial_in_neg_i(1'b1), .crystal_in_i(1'b0), .cascade_en_i(casc),
        .catch_next_in_i(catch_in), .got_mine_out_o(gm),
        .rx_data_o(rx_data),
        .rx_cmd_o(rx_cmd), .data_strobe_o(dstb), .command_strobe_o(cstb),
        .rx_byte_clk_o(rbclk), .rx_locked_o(locked));

    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Sampled on the falling edge so registered outputs have settled
    always @(negedge mclk_i) begin
        if (dstb === 1'b1) begin
            if (exp_q.size() == 0)
                chk("data_strobe", 10'h000, 10'h001);
            else
                chk("rx_data", exp_q.pop_front(), rx_data);
        end
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    always @(negedge mclk_i) begin
        gap++;
        if (rbclk === 1'b1 && rbclk_d !== 1'b1) begin
            chk("rclk_gap", 10'h001, 10'(gap >= BYTE_MIN_CYC));
            gap = 0;
        end
        rbclk_d = rbclk;
    end

    task automatic run_mode(input logic [1:0] m);
        int          dw;
        logic [11:0] w;
        int          k;
        logic [3:0]  c;
        @(negedge mclk_i);
        wmode = m;
        dw = (m == 2'h1) ? 9 : (m == 2'h2) ? 10 : 8;
        // Let idle sync slots realign the receiver after a width change
        k = 0;
        repeat (600) @(negedge mclk_i);
        while (locked !== 1'b1 && k < 3000) begin
            @(negedge mclk_i);
            k++;
        end
        chk("locked", 10'h001, {9'h000, locked});
        for (int i = 0; i < 9; i++) begin
            w = 12'($urandom) & (12'h0fff >> (12 - dw));
            if (i == 2) begin
                @(negedge bclk);
            end else begin
                exp_q.push_back(w[9:0]);
                if (i < 5)
                    host_u.sync_send(w);
                else
                    host_u.send(w);
            end
        end
        k = 0;
        while (exp_q.size() != 0 && k < 3000) begin
            @(negedge mclk_i);
            k++;
        end
        chk("pending", 10'h000, 10'(exp_q.size()));
        c = 4'($urandom_range((1 << (12 - dw)) - 1, 1));
        host_u.send(12'(c) << dw);
        k = 0;
        while (!(cstb === 1'b1 && rx_cmd !== 4'h0) && k < 600) begin
            @(negedge mclk_i);
            k++;
        end
        chk("rx_cmd", {6'h00, c}, {6'h00, rx_cmd});
        @(negedge mclk_i);
        k = 0;
        while (cstb !== 1'b1 && k < 600) begin
            @(negedge mclk_i);
            k++;
        end
        chk("cmd_after_sync", 10'h000, {6'h00, rx_cmd});
        chk("data_kept", 10'(w[9:0]), rx_data);
        $display("test width mode %0d done", m);
    endtask : run_mode

    task automatic run_cascade();
        logic [11:0] w;
        int          k;
        @(negedge mclk_i);
        casc = 1'b1;
        repeat (400) @(negedge mclk_i);
        w = 12'($urandom) & 12'h0ff;
        exp_q.push_back(w[9:0]);
        host_u.send(w);
        k = 0;
        while (gm !== 1'b1 && k < 600) begin
            @(negedge mclk_i);
            k++;
        end
        chk("got_mine", 10'h001, {9'h000, gm});
        k = 0;
        while (exp_q.size() != 0 && k < 600) begin
            @(negedge mclk_i);
            k++;
        end
        chk("held_word", 10'h000, 10'(exp_q.size()));
        chk("got_mine_low", 10'h000, {9'h000, gm});
        catch_in = 1'b0;
        repeat (8) @(negedge mclk_i);
        host_u.send(~w & 12'h0ff);
        repeat (600) @(negedge mclk_i);
        chk("catch_low", 10'(w[7:0]), rx_data);
        $display("test cascade done");
    endtask : run_cascade

    initial begin
        err_count  = 0;
        n_compared = 0;
        cyc        = 0;
        gap        = 1000;
        casc       = 1'b0;
        catch_in   = 1'b1;
        wmode      = 2'h0;
        sys_rst_i  = 1'b1;
        void'($urandom(49532));
        // Held over link clock cycles so all four synchronisers clear
        repeat (4) @(negedge link_clk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        for (int m = 0; m < 4; m++)
            run_mode(2'(m));
        run_cascade();
        wrap_up();
    end
endmodule : slcal_top_tb
